// File: design/gp_pin_pkg.sv
// Constants for the general purpose page pin function selection block
package gp_pin_pkg;

	// ==========================================================================
	// Page selection
	localparam logic [4:0]  PAGE_SEL_ADDR   = 5'h1f;   // Page select register
	localparam logic [15:0] PAGE_MAIN       = 16'h0000;
	localparam logic [15:0] PAGE_GP         = 16'h0010;

	// ==========================================================================
	// Register addresses inside the general purpose page
	localparam logic [4:0]  RSVD_LAST_ADDR  = 5'h0c;   // 0 to this are reserved
	localparam logic [4:0]  PIN_SEL1_ADDR   = 5'h0d;
	localparam logic [4:0]  PIN_SEL2_ADDR   = 5'h0e;
	localparam logic [4:0]  GPIO_IN_ADDR    = 5'h0f;
	localparam logic [4:0]  GPIO_OUT_ADDR   = 5'h10;
	localparam logic [4:0]  GPIO_OE_ADDR    = 5'h11;
	localparam logic [4:0]  RSVD_TOP_ADDR   = 5'h1e;

	// ==========================================================================
	// Reset values and writable bits
	localparam logic [15:0] PIN_SEL1_RST    = 16'h0000;
	localparam logic [15:0] PIN_SEL2_RST    = 16'h2600;
	localparam logic [15:0] PIN_SEL1_WMASK  = 16'h0f0f;
	localparam logic [15:0] PIN_SEL2_WMASK  = 16'hf7ff;
	localparam logic [15:0] GPIO_MASK       = 16'h3f33;  // GPIO capable pins
	localparam logic [15:0] ZERO16          = 16'h0000;

	// ==========================================================================
	// Field positions (low bit of each two-bit selector, then single control bits)
	localparam int SCL1_LSB    = 10;
	localparam int SCL0_LSB    = 8;
	localparam int SDET1_LSB   = 2;
	localparam int SDET0_LSB   = 0;
	localparam int TSPI_LSB    = 14;
	localparam int PPS_LSB     = 6;
	localparam int LDSV_LSB    = 4;
	localparam int QLL_LSB     = 2;
	localparam int SDA_LSB     = 0;
	localparam int PD_OE_N_BIT = 13;
	localparam int PD_OUT_BIT  = 12;
	localparam int PD_IN_BIT   = 11;
	localparam int TW_TRI_BIT  = 10;
	localparam int LED_TRI_BIT = 9;
	localparam int PPS_OE_BIT  = 8;

	// ==========================================================================
	// Selector codes
	localparam logic [1:0]  SEL_DEDICATED   = 2'h0;
	localparam logic [1:0]  SEL_GPIO        = 2'h3;

	// ==========================================================================
	// Pin numbering of the shared pin vector
	localparam int NPINS     = 14;
	localparam int NLEDS     = 4;
	localparam int PIN_SDET0 = 0;
	localparam int PIN_SDET1 = 1;
	localparam int PIN_SCL0  = 4;
	localparam int PIN_SCL1  = 5;
	localparam int PIN_SDA   = 8;
	localparam int PIN_QLL   = 9;
	localparam int PIN_LDSV  = 10;
	localparam int PIN_PPS   = 11;
	localparam int PIN_TCS   = 12;
	localparam int PIN_TDO   = 13;

endpackage

// File: design/pin_level_sync.sv
// Three stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_level_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,      // System clock
	input  wire logic         sys_rst,  // Synchronous reset, high
	input  wire logic [W-1:0] async_i,  // Asynchronous levels
	output logic      [W-1:0] level_q   // Filtered synchronous levels
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	// Stage chain
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a level once second and third stage agree
	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			level_q <= '0;
		end else begin
			level_q <= (agree & s3_q) | (~agree & level_q);
		end
	end

endmodule // pin_level_sync

// File: design/gp_page_pin_function_select.sv
// General purpose page: pin function select, power-down pin and output drive control
//
// Operation
// RL1 - Software writes 0x0010 to reg 31
// RL2 - Writing 0x0000 to reg 31 restores main
// RL3 - Page registers visible only at page 0x0010
// RL4 - Page bits survive partial resets
// RL5 - Addresses 0 to 12, 30 reserved
// RL6 - Bits 11:10 select second clock pin
// RL7 - Bits 9:8 select first clock pin
// RL8 - Bits 3:2, 1:0 select signal detect
// RL9 - Bits 15:14 select chip-select, data-out pins
// RL10 - Bit 13 low makes power-down pin output
// RL11 - Power-down pin driven with bit 12
// RL12 - Bit 11 reads power-down pin level
// RL13 - Bit 10 tri-states two-wire high outputs
// RL14 - Bit 9 tri-states high LED outputs
// RL15 - Bit 8 enables timing pulses one-three
// RL16 - Bits 7:6 select pulse-per-second pin
// RL17 - Bits 5:4 select load/save pin
// RL18 - Bits 3:2 select quick link loss
// RL19 - Bits 1:0 select two-wire data pin
// RL20 - GPIO input register returns pin levels
// RL21 - GPIO pins driven only when enabled
`timescale 1ns/1ns
module gp_page_pin_function_select
	import gp_pin_pkg::*;
(
	input  wire logic             clk,             // System clock, 100 MHz
	input  wire logic             sys_rst,         // Full reset, synchronous, high
	input  wire logic             soft_rst,        // Partial reset, keeps page bits
	input  wire logic             reg_wr,          // Management write strobe
	input  wire logic             reg_rd,          // Management read strobe
	input  wire logic [4:0]       reg_addr,        // Management register address
	input  wire logic [15:0]      reg_wdata,       // Management write data
	output logic      [15:0]      reg_rdata_q,     // Read data
	output logic                  reg_rvalid_q,    // Read data valid pulse
	output logic                  reg_other_q,     // Read was for another page
	output logic      [15:0]      page_q,          // Page select value
	input  wire logic [NPINS-1:0] pin_i,           // Shared pin levels
	output logic      [NPINS-1:0] pin_o,           // Shared pin output values
	output logic      [NPINS-1:0] pin_oe,          // Shared pin output enables
	input  wire logic [NPINS-1:0] func_o,          // Dedicated function outputs
	input  wire logic [NPINS-1:0] func_oe,         // Dedicated function enables
	output logic      [NPINS-1:0] func_i_q,        // Pin levels to functions
	output logic      [NPINS-1:0] gpio_mode_q,     // Pins in GPIO operation
	input  wire logic [NLEDS-1:0] led_i,           // LED values from core
	output logic      [NLEDS-1:0] led_o,           // LED pin outputs
	output logic      [NLEDS-1:0] led_oe,          // LED pin enables
	input  wire logic             power_down_hold_pin_i,  // Power-down pin level
	output logic                  power_down_hold_pin_o,  // Power-down pin value
	output logic                  power_down_hold_pin_oe, // Power-down pin enable
	output logic                  pps_aux_oe_q     // Timing pulses one-three enable
);

	// ==========================================================================
	// Storage
	logic [15:0]      sel1_q;
	logic [15:0]      sel2_q;
	logic [15:0]      gpio_out_q;
	logic [15:0]      gpio_oe_q;
	logic [NPINS:0]   sync_lvl;
	logic [NPINS-1:0] pin_lvl;
	logic             pd_lvl;
	logic             gp_page;
	logic             gp_wr;
	logic [NPINS-1:0] mode_d;
	logic [NPINS-1:0] tw_pin;
	logic [NPINS-1:0] pin_o_d;
	logic [NPINS-1:0] pin_oe_d;
	logic [15:0]      rdata_d;
	logic [15:0]      sel2_view;

	// Which selector codes put each shared pin into GPIO operation
	function automatic logic [NPINS-1:0] gpio_modes(input logic [15:0] s1, input logic [15:0] s2);
		logic [NPINS-1:0] m;
		m            = '0;
		m[PIN_SCL1]  = (s1[SCL1_LSB +: 2] == SEL_GPIO);  // RL6
		m[PIN_SCL0]  = (s1[SCL0_LSB +: 2] == SEL_GPIO);  // RL7
		m[PIN_SDET1] = (s1[SDET1_LSB +: 2] == SEL_GPIO); // RL8
		m[PIN_SDET0] = (s1[SDET0_LSB +: 2] == SEL_GPIO); // RL8
		m[PIN_TCS]   = (s2[TSPI_LSB +: 2] == SEL_GPIO);  // RL9
		m[PIN_TDO]   = (s2[TSPI_LSB +: 2] == SEL_GPIO);  // RL9
		m[PIN_PPS]   = (s2[PPS_LSB +: 2] == SEL_GPIO);   // RL16
		m[PIN_LDSV]  = (s2[LDSV_LSB +: 2] == SEL_GPIO);  // RL17
		m[PIN_QLL]   = (s2[QLL_LSB +: 2] == SEL_GPIO);   // RL18
		m[PIN_SDA]   = (s2[SDA_LSB +: 2] == SEL_GPIO);   // RL19
		return m;
	endfunction

	// Reserved address decode used by the read path
	function automatic logic is_reserved(input logic [4:0] a);
		return (a <= RSVD_LAST_ADDR) || (a == RSVD_TOP_ADDR); // RL5
	endfunction

	// ==========================================================================
	// Input synchronisers: shared pins and power-down pin
	pin_level_sync #(
		.W (NPINS + 1)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.async_i ({power_down_hold_pin_i, pin_i}),
		.level_q (sync_lvl)
	);

	assign pin_lvl = sync_lvl[NPINS-1:0];
	assign pd_lvl  = sync_lvl[NPINS];

	// ==========================================================================
	// Page select register
	assign gp_page = (page_q == PAGE_GP);                                  // RL3
	assign gp_wr   = reg_wr && gp_page && (reg_addr != PAGE_SEL_ADDR);     // RL3

	// Page register returns to main page on any reset
	always_ff @(posedge clk) begin
		if (sys_rst || soft_rst) begin
			page_q <= PAGE_MAIN;
		end else if (reg_wr && (reg_addr == PAGE_SEL_ADDR)) begin
			page_q <= reg_wdata;                                           // RL1 RL2
		end
	end

	// ==========================================================================
	// Pin function select registers, held through partial reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sel1_q <= PIN_SEL1_RST;
		end else if (gp_wr && (reg_addr == PIN_SEL1_ADDR)) begin
			sel1_q <= reg_wdata & PIN_SEL1_WMASK;                          // RL4 RL5
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sel2_q <= PIN_SEL2_RST;
		end else if (gp_wr && (reg_addr == PIN_SEL2_ADDR)) begin
			sel2_q <= reg_wdata & PIN_SEL2_WMASK;                          // RL4
		end
	end

	// GPIO output and enable registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gpio_out_q <= ZERO16;
		end else if (gp_wr && (reg_addr == GPIO_OUT_ADDR)) begin
			gpio_out_q <= reg_wdata & GPIO_MASK;                           // RL4
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gpio_oe_q <= ZERO16;
		end else if (gp_wr && (reg_addr == GPIO_OE_ADDR)) begin
			gpio_oe_q <= reg_wdata & GPIO_MASK;                            // RL4
		end
	end

	// ==========================================================================
	// Read path
	assign sel2_view = {sel2_q[15:PD_IN_BIT+1], pd_lvl, sel2_q[PD_IN_BIT-1:0]}; // RL12

	always_comb begin
		rdata_d = ZERO16;
		if (reg_addr == PAGE_SEL_ADDR) begin
			rdata_d = page_q;
		end else if (gp_page && !is_reserved(reg_addr)) begin
			unique case (reg_addr)
				PIN_SEL1_ADDR: rdata_d = sel1_q;
				PIN_SEL2_ADDR: rdata_d = sel2_view;
				GPIO_IN_ADDR:  rdata_d = {2'h0, pin_lvl} & GPIO_MASK;      // RL20
				GPIO_OUT_ADDR: rdata_d = gpio_out_q;
				GPIO_OE_ADDR:  rdata_d = gpio_oe_q;
				default:       rdata_d = ZERO16;
			endcase
		end
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst || soft_rst) begin
			reg_rdata_q  <= ZERO16;
			reg_rvalid_q <= 1'b0;
			reg_other_q  <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd;
			reg_other_q  <= reg_rd && !gp_page && (reg_addr != PAGE_SEL_ADDR); // RL3
			if (reg_rd) begin
				reg_rdata_q <= rdata_d;
			end
		end
	end

	// ==========================================================================
	// Shared pin multiplexer
	assign mode_d = gpio_modes(sel1_q, sel2_q);

	// Two-wire serial clock and data pins
	always_comb begin
		tw_pin           = '0;
		tw_pin[PIN_SCL0] = 1'b1;
		tw_pin[PIN_SCL1] = 1'b1;
		tw_pin[PIN_SDA]  = 1'b1;
	end

	// Per pin choice between dedicated function and GPIO
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_pin
			// GPIO registers win, otherwise the dedicated function drives
			assign pin_o_d[gi]  = mode_d[gi] ? gpio_out_q[gi] : func_o[gi];
			// Two-wire pins release the line rather than drive it high
			assign pin_oe_d[gi] = mode_d[gi] ? gpio_oe_q[gi] :                                // RL21
				(tw_pin[gi] && sel2_q[TW_TRI_BIT]) ? (func_oe[gi] && !func_o[gi]) :         // RL13
				func_oe[gi];
		end
	endgenerate

	// Registered pin drive and readback to functions
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_o       <= '0;
			pin_oe      <= '0;
			func_i_q    <= '0;
			gpio_mode_q <= '0;
		end else begin
			pin_o       <= pin_o_d;
			pin_oe      <= pin_oe_d;
			func_i_q    <= pin_lvl & ~mode_d;
			gpio_mode_q <= mode_d;
		end
	end

	// ==========================================================================
	// LED drive: tri-state instead of driving high
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			led_o  <= '0;
			led_oe <= '0;
		end else begin
			led_o  <= led_i;
			led_oe <= sel2_q[LED_TRI_BIT] ? ~led_i : {NLEDS{1'b1}};        // RL14
		end
	end

	// ==========================================================================
	// Power-down pin and timing pulse enable
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			power_down_hold_pin_o  <= 1'b0;
			power_down_hold_pin_oe <= 1'b0;
			pps_aux_oe_q           <= 1'b0;
		end else begin
			power_down_hold_pin_oe <= !sel2_q[PD_OE_N_BIT];                // RL10
			power_down_hold_pin_o  <= sel2_q[PD_OUT_BIT];                  // RL11
			pps_aux_oe_q           <= sel2_q[PPS_OE_BIT];                  // RL15
		end
	end

	// ==========================================================================
	// Assertions
	sequence s_enter_gp;
		reg_wr && (reg_addr == PAGE_SEL_ADDR) && (reg_wdata == PAGE_GP);
	endsequence

	sequence s_write_sel2_gpio_pps;
		reg_wr && (reg_addr == PIN_SEL2_ADDR) && (reg_wdata[PPS_LSB +: 2] == SEL_GPIO);
	endsequence

	property p_page_gp;
		@(posedge clk) disable iff (sys_rst || soft_rst)
		s_enter_gp |=> gp_page;
	endproperty
	a_page_gp: assert property (p_page_gp) else $error("page not set to general purpose"); // RL1

	property p_page_main;
		@(posedge clk) disable iff (sys_rst || soft_rst)
		reg_wr && (reg_addr == PAGE_SEL_ADDR) && (reg_wdata == PAGE_MAIN) |=> (page_q == PAGE_MAIN) && !gp_page;
	endproperty
	a_page_main: assert property (p_page_main) else $error("page not returned to main"); // RL2

	property p_hidden;
		@(posedge clk) disable iff (sys_rst)
		reg_wr && !gp_page && (reg_addr == PIN_SEL1_ADDR) |=> $stable(sel1_q);
	endproperty
	a_hidden: assert property (p_hidden) else $error("write reached hidden register"); // RL3

	property p_sticky;
		@(posedge clk) disable iff (sys_rst)
		soft_rst |=> $stable(sel2_q) && $stable(gpio_oe_q);
	endproperty
	a_sticky: assert property (p_sticky) else $error("page bits lost on partial reset"); // RL4

	property p_reserved;
		@(posedge clk) disable iff (sys_rst || soft_rst)
		reg_rd && gp_page && is_reserved(reg_addr) |=> reg_rvalid_q && (reg_rdata_q == ZERO16);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved address read non-zero"); // RL5

	property p_pd_drive;
		@(posedge clk) disable iff (sys_rst)
		##1 (power_down_hold_pin_oe == !$past(sel2_q[PD_OE_N_BIT]))
			&& (power_down_hold_pin_o == $past(sel2_q[PD_OUT_BIT]));
	endproperty
	a_pd_drive: assert property (p_pd_drive) else $error("power-down pin drive wrong"); // RL10 RL11

	property p_pd_read;
		@(posedge clk) disable iff (sys_rst || soft_rst)
		reg_rd && gp_page && (reg_addr == PIN_SEL2_ADDR) |=> reg_rdata_q[PD_IN_BIT] == $past(pd_lvl);
	endproperty
	a_pd_read: assert property (p_pd_read) else $error("power-down pin readback wrong"); // RL12

	property p_tw_tristate;
		@(posedge clk) disable iff (sys_rst)
		!mode_d[PIN_SDA] && sel2_q[TW_TRI_BIT] && func_o[PIN_SDA] |=> !pin_oe[PIN_SDA];
	endproperty
	a_tw_tristate: assert property (p_tw_tristate) else $error("two-wire pin driven high"); // RL13

	property p_led_tristate;
		@(posedge clk) disable iff (sys_rst)
		sel2_q[LED_TRI_BIT] && led_i[0] |=> !led_oe[0] && led_o[0];
	endproperty
	a_led_tristate: assert property (p_led_tristate) else $error("LED driven high"); // RL14

	property p_pps_aux;
		@(posedge clk) disable iff (sys_rst)
		##1 pps_aux_oe_q == $past(sel2_q[PPS_OE_BIT]);
	endproperty
	a_pps_aux: assert property (p_pps_aux) else $error("timing pulse enable wrong"); // RL15

	property p_pps_gpio;
		@(posedge clk) disable iff (sys_rst || soft_rst)
		s_enter_gp ##2 s_write_sel2_gpio_pps |=> ##1 gpio_mode_q[PIN_PPS]
			&& (pin_oe[PIN_PPS] == $past(gpio_oe_q[PIN_PPS]));
	endproperty
	a_pps_gpio: assert property (p_pps_gpio) else $error("pulse pin not in GPIO mode"); // RL16 RL21

	property p_gpio_in;
		@(posedge clk) disable iff (sys_rst || soft_rst)
		reg_rd && gp_page && (reg_addr == GPIO_IN_ADDR) |=> reg_rdata_q[PIN_SDA] == $past(pin_lvl[PIN_SDA]);
	endproperty
	a_gpio_in: assert property (p_gpio_in) else $error("GPIO input readback wrong"); // RL20

endmodule // gp_page_pin_function_select

// File: tb/board_pin_model.sv
// Board model: resolves shared pin, power-down pin and LED levels
`timescale 1ns/1ns
module board_pin_model
	import gp_pin_pkg::*;
(
	input  wire logic             clk,       // System clock
	input  wire logic [NPINS-1:0] pin_o,     // Device pin values
	input  wire logic [NPINS-1:0] pin_oe,    // Device pin enables
	input  wire logic [NPINS-1:0] ext_o,     // Board driver values
	input  wire logic [NPINS-1:0] ext_oe,    // Board driver enables
	output logic      [NPINS-1:0] pin_lvl,   // Resolved pin levels
	input  wire logic             pd_o,      // Device power-down value
	input  wire logic             pd_oe,     // Device power-down enable
	input  wire logic             pd_ext_o,  // Board power-down value
	input  wire logic             pd_ext_oe, // Board power-down enable
	output logic                  pd_lvl,    // Resolved power-down level
	input  wire logic [NLEDS-1:0] led_o,     // Device LED values
	input  wire logic [NLEDS-1:0] led_oe,    // Device LED enables
	output logic      [NLEDS-1:0] led_lvl    // Resolved LED levels
);
	// ==========================================================================
	// Pin resolution
	localparam logic [NPINS-1:0] PULL_UP = 14'h0130; // Two-wire pins
	logic [NPINS-1:0] last_q;
	logic             pd_last_q;

	// Floating lines show the inverse of their last level
	always_ff @(posedge clk) begin
		last_q    <= pin_lvl;
		pd_last_q <= pd_lvl;
	end

	// Device first, then board driver, then pull-up or float
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			pin_lvl[i] = pin_oe[i] ? pin_o[i] : ext_oe[i] ? ext_o[i] : PULL_UP[i] ? 1'b1 : ~last_q[i];
		end
		for (int j = 0; j < NLEDS; j++) begin
			led_lvl[j] = led_oe[j] ? led_o[j] : 1'b1;
		end
		pd_lvl = pd_oe ? pd_o : pd_ext_oe ? pd_ext_o : ~pd_last_q;
	end
endmodule // board_pin_model

// File: tb/test_gp_page_pin_function_select.sv
// Self-checking bench for the pin function select block
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_gp_page_pin_function_select
	import gp_pin_pkg::*;
;
	typedef struct {logic [4:0] a; logic [15:0] d; logic [15:0] e;} row_t;
	logic             clk, sys_rst, soft_rst, reg_wr, reg_rd, reg_rvalid_q, reg_other_q, rd_other;
	logic [4:0]       reg_addr;
	logic [15:0]      reg_wdata, reg_rdata_q, page_q, rd_data;
	logic [NPINS-1:0] pin_lvl, pin_o, pin_oe, func_o, func_oe, func_i_q, gpio_mode_q, ext_o, ext_oe;
	logic [NLEDS-1:0] led_i, led_o, led_oe, led_lvl;
	logic             pd_lvl, pd_o, pd_oe, pd_ext_o, pd_ext_oe, pps_aux_oe_q;
	int               bad_count, cmp_count;
	// Write, settle, read back
	row_t rows [13] = '{
		'{5'h0d, 16'hffff, 16'h0f0f}, '{5'h0d, 16'h5a5a, 16'h0a0a}, '{5'h0d, 16'h0000, 16'h0000},
		'{5'h0e, 16'hffff, 16'hffff}, '{5'h0e, 16'h0800, 16'h0000}, '{5'h0e, 16'h1000, 16'h1800},
		'{5'h0e, 16'h2600, 16'h2e00}, '{5'h10, 16'hffff, 16'h3f33}, '{5'h11, 16'h0000, 16'h0000},
		'{5'h05, 16'hffff, 16'h0000}, '{5'h1e, 16'hffff, 16'h0000}, '{5'h0c, 16'hffff, 16'h0000},
		'{5'h10, 16'h0000, 16'h0000}};
	// Selector fields: register, low bit, pins, register base
	logic [4:0]       f_addr [9] = '{5'h0d, 5'h0d, 5'h0d, 5'h0d, 5'h0e, 5'h0e, 5'h0e, 5'h0e, 5'h0e};
	int               f_lsb  [9] = '{10, 8, 2, 0, 14, 6, 4, 2, 0};
	logic [NPINS-1:0] f_pins [9] = '{14'h0020, 14'h0010, 14'h0002, 14'h0001, 14'h3000, 14'h0800, 14'h0400,
		14'h0200, 14'h0100};
	logic [15:0]      f_base [9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h2600, 16'h2600, 16'h2600, 16'h2600, 16'h2600};

	// ==========================================================================
	// Instances
	gp_page_pin_function_select gp_page_pin_function_select_i (.clk(clk), .sys_rst(sys_rst),
		.soft_rst(soft_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .reg_other_q(reg_other_q), .page_q(page_q),
		.pin_i(pin_lvl), .pin_o(pin_o), .pin_oe(pin_oe), .func_o(func_o), .func_oe(func_oe),
		.func_i_q(func_i_q), .gpio_mode_q(gpio_mode_q), .led_i(led_i), .led_o(led_o), .led_oe(led_oe),
		.power_down_hold_pin_i(pd_lvl), .power_down_hold_pin_o(pd_o), .power_down_hold_pin_oe(pd_oe),
		.pps_aux_oe_q(pps_aux_oe_q));
	board_pin_model board_pin_model_i (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .ext_o(ext_o),
		.ext_oe(ext_oe), .pin_lvl(pin_lvl), .pd_o(pd_o), .pd_oe(pd_oe), .pd_ext_o(pd_ext_o),
		.pd_ext_oe(pd_ext_oe), .pd_lvl(pd_lvl), .led_o(led_o), .led_oe(led_oe), .led_lvl(led_lvl));

	// ==========================================================================
	// Tasks
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		`CHK(reg_rvalid_q, 1'b1)
		rd_data  = reg_rdata_q;
		rd_other = reg_other_q;
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========================================================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#100000;
		bad_count++;
		tally_and_finish;
	end

	// ==========================================================================
	// Main sequence
	initial begin
		{sys_rst, soft_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0000};
		{func_o, func_oe, ext_o, ext_oe, led_i} = {14'h0000, 14'h3fff, 14'h0000, 14'h3fff, 4'h0};
		{pd_ext_o, pd_ext_oe, bad_count, cmp_count} = {1'b1, 1'b1, 32'd0, 32'd0};
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		settle(6);
		// Defaults
		`CHK(pd_oe, 1'b0)
		`CHK(pps_aux_oe_q, 1'b0)
		wr(PAGE_SEL_ADDR, 16'h0010);
		rd(5'h0d);
		`CHK(rd_data, 16'h0000)
		`CHK(rd_other, 1'b0)
		rd(5'h0e);
		`CHK(rd_data, 16'h2e00)
		// Table rows
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			settle(6);
			rd(rows[i].a);
			`CHK(rd_data, rows[i].e)
		end
		// Every code of every selector
		for (int k = 0; k < 9; k++) begin
			for (int c = 0; c < 4; c++) begin
				wr(f_addr[k], f_base[k] | (16'(c) << f_lsb[k]));
				settle(3);
				`CHK(gpio_mode_q, (c == 3) ? f_pins[k] : 14'h0000)
			end
			wr(f_addr[k], f_base[k]);
		end
		// GPIO drive and input readback
		wr(5'h0d, 16'h0f0f);
		wr(PAGE_SEL_ADDR, 16'h0010);
		wr(5'h0e, 16'he6ff);
		wr(5'h11, 16'h0033);
		wr(5'h10, 16'h0011);
		@(posedge clk);
		{ext_o, ext_oe} <= {14'h2a00, 14'h3f00};
		settle(6);
		`CHK(pin_oe & 14'h3f33, 14'h0033)
		`CHK(pin_o & 14'h0033, 14'h0011)
		rd(5'h0f);
		`CHK(rd_data, 16'h2a11)
		// Two-wire and LED tri-state, timing pulse enable
		wr(5'h0d, 16'h0000);
		wr(5'h0e, 16'h2600);
		@(posedge clk);
		{func_o, ext_oe, led_i} <= {14'h0130, 14'h0000, 4'h5};
		settle(6);
		`CHK(pin_oe & 14'h0130, 14'h0000)
		`CHK(func_i_q & 14'h0130, 14'h0130)
		`CHK(led_oe, 4'ha)
		`CHK(led_lvl, 4'h5)
		`CHK(led_o, 4'h5)
		wr(5'h0e, 16'h2100);
		settle(2);
		`CHK(pin_oe & 14'h0130, 14'h0130)
		`CHK(pin_o & 14'h0130, 14'h0130)
		`CHK(led_oe, 4'hf)
		`CHK(pps_aux_oe_q, 1'b1)
		// Power-down pin
		wr(5'h0e, 16'h1600);
		settle(2);
		`CHK(pd_oe, 1'b1)
		`CHK(pd_o, 1'b1)
		@(posedge clk);
		pd_ext_o <= 1'b0;
		wr(5'h0e, 16'h2600);
		settle(6);
		`CHK(pd_oe, 1'b0)
		`CHK(pps_aux_oe_q, 1'b0)
		rd(5'h0e);
		`CHK(rd_data, 16'h2600)
		// Page switching
		wr(PAGE_SEL_ADDR, 16'h0000);
		settle(1);
		`CHK(page_q, 16'h0000)
		rd(5'h0d);
		`CHK(rd_other, 1'b1)
		`CHK(rd_data, 16'h0000)
		wr(5'h0d, 16'h0f0f);
		wr(PAGE_SEL_ADDR, 16'h0010);
		rd(5'h0d);
		`CHK(rd_data, 16'h0000)
		// Partial reset keeps page bits, full reset does not
		wr(5'h0d, 16'h0f0f);
		@(posedge clk);
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		settle(1);
		`CHK(page_q, 16'h0000)
		wr(PAGE_SEL_ADDR, 16'h0010);
		rd(5'h0d);
		`CHK(rd_data, 16'h0f0f)
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		settle(6);
		wr(PAGE_SEL_ADDR, 16'h0010);
		rd(5'h0d);
		`CHK(rd_data, 16'h0000)
		tally_and_finish;
	end
endmodule // test_gp_page_pin_function_select
